// ==== hdl/mct_pkg.sv ====
package mct_pkg;
    localparam int          AXES         = 4;
    localparam int          STEP_W       = 32;
    localparam int          POS_W        = 32;
    localparam int          TMO_W        = 16;
    // APB register byte offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_TMO      = 8'h08;
    localparam logic [7:0]  OFS_STOP     = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0]  OFS_IRQ_CLR  = 8'h14;
    localparam logic [7:0]  OFS_IRQ_EN   = 8'h18;
    // Reset values and codes
    localparam logic [15:0] TMO_RESET    = 16'h0000;
    localparam logic [7:0]  STOP_TIMEOUT = 8'h63;   // decimal 99
    localparam logic [7:0]  STOP_RESET   = 8'h00;
    localparam logic [1:0]  THREAD_ZERO  = 2'h0;
    // Time base
    localparam int          CLK_HZ       = 25_000_000;
    localparam int          MS_PER_S     = 1000;
    localparam int          CYC_PER_MS   = CLK_HZ / MS_PER_S;
    localparam int          MS_CNT_W     = 15;
    // Interrupt bits
    localparam int          IRQ_DONE     = 0;
    localparam int          IRQ_TMO      = 1;
    localparam int          IRQ_W        = 2;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT} mct_state_t;
endpackage : mct_pkg

// ==== hdl/mct_motion_complete.sv ====
`timescale 1ns/100ps
module mct_motion_complete #(
    parameter int AXES   = mct_pkg::AXES,
    parameter int POS_W  = mct_pkg::POS_W,
    parameter int STEP_W = mct_pkg::STEP_W,
    parameter int MS_CYC = mct_pkg::CYC_PER_MS
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    waitIssue,
    input  wire logic [AXES-1:0]         waitMask,
    input  wire logic [1:0]              waitThread,
    output logic                         threadStall,
    output logic                         threadRelease,
    output logic                         handlerJump,
    input  wire logic                    handlerDefined,
    input  wire logic [AXES-1:0]         profDone,
    input  wire logic [AXES-1:0]         axisIsStepper,
    input  wire logic [AXES*POS_W-1:0]   encPos,
    input  wire logic [AXES*POS_W-1:0]   cmdPos,
    input  wire logic [AXES-1:0]         moveStart,
    input  wire logic [AXES*STEP_W-1:0]  moveSteps,
    input  wire logic [AXES-1:0]         stepPulse,
    output logic                         irq
);
    mct_pkg::mct_state_t stateQ;
    logic [AXES-1:0]          maskQ;
    logic [AXES-1:0]          axisDone;
    logic [AXES-1:0]          settling;
    logic [AXES*STEP_W-1:0]   stepLeftQ;
    logic [15:0]              tmoSetQ;
    logic [15:0]              msCntQ;
    logic [mct_pkg::MS_CNT_W-1:0] cycCntQ;
    logic [7:0]               stopQ;
    logic [mct_pkg::IRQ_W-1:0] irqStatQ;
    logic [mct_pkg::IRQ_W-1:0] irqEnQ;
    logic                     apbWr;
    logic                     anyDone;
    logic                     timeoutHit;
    logic [mct_pkg::IRQ_W-1:0] irqEvt;

    // Step pulses counted down per axis; a new move reloads the count
    genvar g;
    for (g = 0; g < AXES; g++) begin : gAxis
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                stepLeftQ[g*STEP_W +: STEP_W] <= '0;
            end else if (moveStart[g]) begin
                stepLeftQ[g*STEP_W +: STEP_W] <= moveSteps[g*STEP_W +: STEP_W];
            end else if (stepPulse[g] &&
                         stepLeftQ[g*STEP_W +: STEP_W] != '0) begin
                stepLeftQ[g*STEP_W +: STEP_W] <=
                    stepLeftQ[g*STEP_W +: STEP_W] - 1'b1;
            end
        end
        always_comb begin
            if (axisIsStepper[g]) begin
                axisDone[g] = profDone[g] &&
                              stepLeftQ[g*STEP_W +: STEP_W] == '0;
            end else begin
                axisDone[g] = profDone[g] && encPos[g*POS_W +: POS_W]
                              == cmdPos[g*POS_W +: POS_W];
            end
            settling[g] = profDone[g] && !axisDone[g];
        end
    end

    assign anyDone = |(axisDone & maskQ);
    assign timeoutHit = (stateQ == mct_pkg::ST_WAIT) && !anyDone
                        && tmoSetQ != '0 && msCntQ >= tmoSetQ;
    assign threadStall = (stateQ == mct_pkg::ST_WAIT);
    assign threadRelease = threadStall && (anyDone || timeoutHit);
    assign apbWr = psel && penable && pwrite;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stateQ <= mct_pkg::ST_IDLE;
            maskQ  <= '0;
        end else begin
            unique case (stateQ)
                mct_pkg::ST_IDLE: begin
                    if (waitIssue) begin
                        stateQ <= mct_pkg::ST_WAIT;
                        maskQ  <= (waitMask == '0) ? '1 : waitMask;
                    end
                end
                mct_pkg::ST_WAIT: begin
                    if (anyDone || timeoutHit) begin
                        stateQ <= mct_pkg::ST_IDLE;
                    end
                end
                default: stateQ <= mct_pkg::ST_IDLE;
            endcase
        end
    end

    // Millisecond settle timer; any settling selected axis keeps it running
    always_ff @(posedge sys_clk) begin
        if (!rst_n || waitIssue || stateQ != mct_pkg::ST_WAIT
            || !(|(settling & maskQ))) begin
            cycCntQ <= '0;
            msCntQ  <= '0;
        end else if (cycCntQ == mct_pkg::MS_CNT_W'(MS_CYC - 1)) begin
            cycCntQ <= '0;
            if (msCntQ != '1) begin
                msCntQ <= msCntQ + 1'b1;
            end
        end else begin
            cycCntQ <= cycCntQ + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            handlerJump <= 1'b0;
        end else begin
            handlerJump <= timeoutHit && handlerDefined
                           && waitThread == mct_pkg::THREAD_ZERO;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stopQ <= mct_pkg::STOP_RESET;
        end else if (timeoutHit) begin
            stopQ <= mct_pkg::STOP_TIMEOUT;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tmoSetQ <= mct_pkg::TMO_RESET;
            irqEnQ  <= '0;
        end else if (apbWr && paddr == mct_pkg::OFS_TMO) begin
            tmoSetQ <= pwdata[15:0];
        end else if (apbWr && paddr == mct_pkg::OFS_IRQ_EN) begin
            irqEnQ  <= pwdata[mct_pkg::IRQ_W-1:0];
        end
    end

    // Set wins over a clear in the same cycle
    always_comb begin
        irqEvt = '0;
        irqEvt[mct_pkg::IRQ_DONE] = threadStall && anyDone;
        irqEvt[mct_pkg::IRQ_TMO]  = timeoutHit;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irqStatQ <= '0;
        end else if (apbWr && paddr == mct_pkg::OFS_IRQ_CLR) begin
            irqStatQ <= (irqStatQ & ~pwdata[mct_pkg::IRQ_W-1:0]) | irqEvt;
        end else begin
            irqStatQ <= irqStatQ | irqEvt;
        end
    end

    assign irq = |(irqStatQ & irqEnQ);
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    always_comb begin
        prdata = '0;
        unique case (paddr)
            mct_pkg::OFS_CTRL:     prdata[AXES-1:0] = maskQ;
            mct_pkg::OFS_STATUS:   prdata[1:0] = {timeoutHit, threadStall};
            mct_pkg::OFS_TMO:      prdata[15:0] = tmoSetQ;
            mct_pkg::OFS_STOP:     prdata[7:0] = stopQ;
            mct_pkg::OFS_IRQ_STAT: prdata[mct_pkg::IRQ_W-1:0] = irqStatQ;
            mct_pkg::OFS_IRQ_EN:   prdata[mct_pkg::IRQ_W-1:0] = irqEnQ;
            default:               prdata = '0;
        endcase
    end

    // Wait state and release
    empty_mask_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        stateQ == mct_pkg::ST_IDLE && waitIssue && waitMask == '0
        |=> maskQ == '1) else $error("empty mask not widened");

    release_done_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        threadStall && anyDone |=> !threadStall)
        else $error("stall held after done");

    stall_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        threadStall && !anyDone && !timeoutHit |=> threadStall)
        else $error("stall dropped early");

    issue_stall_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        stateQ == mct_pkg::ST_IDLE && waitIssue |=> threadStall)
        else $error("wait not taken");

    idle_no_rel_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !threadStall |-> !threadRelease)
        else $error("release while idle");

    release_stall_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        threadRelease |=> !threadStall)
        else $error("stall after release");

    any_done_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        threadStall && |(axisDone & maskQ) |-> threadRelease)
        else $error("done axis not released");

    done_flag_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        threadStall && anyDone |=> irqStatQ[mct_pkg::IRQ_DONE])
        else $error("done flag not set");

    // Per-axis completion, checked on axis 0, and the wait mask
    servo_done_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !axisIsStepper[0] && axisDone[0] |-> profDone[0]
        && encPos[POS_W-1:0] == cmdPos[POS_W-1:0])
        else $error("servo done wrongly");

    servo_ok_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !axisIsStepper[0] && profDone[0]
        && encPos[POS_W-1:0] == cmdPos[POS_W-1:0] |-> axisDone[0])
        else $error("servo in position not done");

    no_prof_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !profDone[0] |-> !axisDone[0])
        else $error("done before profiler");

    issue_mask_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        stateQ == mct_pkg::ST_IDLE && waitIssue && waitMask != '0
        |=> maskQ == $past(waitMask)) else $error("mask not latched");

    mask_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        threadStall |=> $stable(maskQ))
        else $error("mask changed while waiting");

    mask_nonzero_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        threadStall |-> maskQ != '0)
        else $error("empty mask while waiting");

    step_done_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        axisIsStepper[0] && stepLeftQ[STEP_W-1:0] != '0 |-> !axisDone[0])
        else $error("stepper done with steps left");

    step_ready_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        axisIsStepper[0] && profDone[0] && stepLeftQ[STEP_W-1:0] == '0
        |-> axisDone[0]) else $error("stepper finished not done");

    step_load_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        moveStart[0] |=> stepLeftQ[STEP_W-1:0]
        == $past(moveSteps[STEP_W-1:0])) else $error("steps not loaded");

    step_dec_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !moveStart[0] && stepPulse[0] && stepLeftQ[STEP_W-1:0] != '0
        |=> stepLeftQ[STEP_W-1:0] == $past(stepLeftQ[STEP_W-1:0]) - 1'b1)
        else $error("step not counted");

    // Settle timeout
    tmo_cause_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        timeoutHit |-> msCntQ >= tmoSetQ && tmoSetQ != '0)
        else $error("timeout without limit");

    tmo_off_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        tmoSetQ == '0 |-> !timeoutHit)
        else $error("timeout while disabled");

    tmo_write_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        apbWr && paddr == mct_pkg::OFS_TMO
        |=> tmoSetQ == $past(pwdata[15:0])) else $error("limit not written");

    tmo_flag_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        timeoutHit |=> irqStatQ[mct_pkg::IRQ_TMO])
        else $error("timeout flag not set");

    set_wins_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        apbWr && paddr == mct_pkg::OFS_IRQ_CLR && irqEvt[mct_pkg::IRQ_TMO]
        |=> irqStatQ[mct_pkg::IRQ_TMO]) else $error("clear beat set");

    stop_code_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        timeoutHit |=> stopQ == 8'h63 && !threadStall)
        else $error("timeout did not set stop code");

    tmo_release_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        timeoutHit |-> threadStall && threadRelease)
        else $error("timeout did not release");

    stop_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !timeoutHit |=> $stable(stopQ))
        else $error("stop cause changed");

    handler_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        timeoutHit && handlerDefined && waitThread == 2'h0 |=> handlerJump)
        else $error("no handler jump");

    no_handler_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        handlerJump |-> $past(timeoutHit) && $past(handlerDefined))
        else $error("spurious handler jump");

    jump_pulse_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        handlerJump |=> !handlerJump)
        else $error("handler jump too long");

    ms_tick_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $changed(msCntQ) && msCntQ != '0 |-> $past(cycCntQ) ==
        mct_pkg::MS_CNT_W'(MS_CYC - 1)) else $error("ms tick wrong");

    ms_step_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $changed(msCntQ) && msCntQ != '0
        |-> msCntQ == $past(msCntQ) + 1'b1) else $error("ms count jumped");

    cyc_range_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cycCntQ <= mct_pkg::MS_CNT_W'(MS_CYC - 1))
        else $error("cycle count overran");

    restart_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        waitIssue |=> msCntQ == '0) else $error("count not cleared");

    idle_clear_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        stateQ != mct_pkg::ST_WAIT |=> cycCntQ == '0 && msCntQ == '0)
        else $error("count kept while idle");
endmodule : mct_motion_complete

// ==== tb/mct_axis_model.sv ====
`timescale 1ns/100ps
module mct_axis_model #(
    parameter int AXES   = 4,
    parameter int POS_W  = 32,
    parameter int STEP_W = 32
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic [AXES-1:0]        cmdGo,
    input  wire logic [AXES-1:0]        cmdStepper,
    input  wire logic [AXES-1:0]        cmdStuck,
    input  wire logic [7:0]             cmdLen,
    input  wire logic [POS_W-1:0]       cmdTarget,
    output logic      [AXES-1:0]        profDone,
    output logic      [AXES*POS_W-1:0]  encPos,
    output logic      [AXES*POS_W-1:0]  cmdPos,
    output logic      [AXES-1:0]        moveStart,
    output logic      [AXES*STEP_W-1:0] moveSteps,
    output logic      [AXES-1:0]        stepPulse
);
    // Profiler ends halfway; steps trail it, as smoothing would
    logic [8:0]       cntQ [AXES];
    logic [7:0]       lenQ [AXES];
    logic [POS_W-1:0] tgtQ [AXES];
    always_ff @(posedge sys_clk) begin
        for (int a = 0; a < AXES; a++) begin
            moveStart[a] <= cmdGo[a] & rst_n;
            stepPulse[a] <= rst_n & cmdStepper[a] & (cntQ[a] != 9'h000)
                            & ~cntQ[a][0];
            if (!rst_n || cmdGo[a]) begin
                cntQ[a] <= rst_n ? {cmdLen, 1'b0} : 9'h000;
                lenQ[a] <= rst_n ? cmdLen : 8'h00;
                tgtQ[a] <= rst_n ? cmdTarget : '0;
            end else if (cntQ[a] != 9'h000) begin
                cntQ[a] <= cntQ[a] - 9'h001;
            end
        end
    end
    always_comb begin
        for (int a = 0; a < AXES; a++) begin
            profDone[a] = cntQ[a] <= {1'b0, lenQ[a]};
            cmdPos[a*POS_W +: POS_W] = tgtQ[a];
            // Off target reads inverted so a stale match never shows
            encPos[a*POS_W +: POS_W] = (cntQ[a] == 9'h000 && !cmdStuck[a])
                                       ? tgtQ[a] : ~tgtQ[a];
            moveSteps[a*STEP_W +: STEP_W] = STEP_W'(lenQ[a]);
        end
    end
endmodule : mct_axis_model

// ==== tb/mct_motion_complete_bench.sv ====
`timescale 1ns/100ps
module mct_motion_complete_bench;
    logic         sys_clk = '0, rst_n = '0, psel = '0, penable = '0;
    logic         pwrite = '0, waitIssue = '0, handlerDefined = '0;
    logic         pready, pslverr, threadStall, threadRelease, handlerJump, irq;
    logic [7:0]   paddr = '0, cmdLen = '0;
    logic [31:0]  pwdata = '0, prdata, rd, cmdTarget = '0;
    logic [3:0]   waitMask = '0, cmdGo = '0, cmdStepper = '0, cmdStuck = '0;
    logic [3:0]   axisIsStepper, profDone, moveStart, stepPulse;
    logic [1:0]   waitThread = '0;
    logic [127:0] encPos, cmdPos, moveSteps;
    logic [15:0]  lfsr = 16'h96B9;
    int           fail_count = 0, checks = 0, pulses, settle, ax;
    assign axisIsStepper = cmdStepper;
    always #20 sys_clk = ~sys_clk;
    mct_motion_complete #(.MS_CYC(4)) mct_motion_complete_i (.*);
    mct_axis_model mct_axis_model_i (.*);
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt
    task automatic chk(input logic [31:0] got, exp, input string m);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        chk(pslverr, 0, "slverr");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic run(input logic [3:0] m, input logic [1:0] t,
                       input logic stk, input logic stp);
        cmdLen <= 8'h04 + {4'h0, lfsr[3:0]};
        cmdTarget <= {lfsr, ~lfsr};
        cmdGo <= 4'hF;
        cmdStuck <= ~(4'h1 << ax) | {4{stk}};
        cmdStepper <= {3'h0, stp} << ax;
        waitIssue <= 1'b1;
        waitMask <= m;
        waitThread <= t;
        @(posedge sys_clk);
        cmdGo <= '0;
        waitIssue <= 1'b0;
        lfsr = nxt(lfsr);
        pulses = 0;
        settle = 0;
        @(negedge sys_clk);
        chk(threadStall, 1, "stall");
        for (int i = 0; i < 3000 && threadRelease !== 1'b1; i++) begin
            @(negedge sys_clk);
            pulses += stepPulse[ax];
            settle += profDone[ax];
        end
        chk(profDone[ax], 1, "prof");
        if (stp) chk(pulses, cmdLen, "steps");
        else if (!stk) chk(encPos[ax*32 +: 32], cmdPos[ax*32 +: 32], "pos");
        @(negedge sys_clk);
        chk(threadStall, 0, "free");
        chk(handlerJump, stk && t == 2'h0 && handlerDefined, "jump");
        @(posedge sys_clk);
    endtask : run
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, k == 3 ? 8'h40 : 8'h08 + 8'(k * 4), 0);
            chk(rd, 0, "reset");
        end
        apb(1'b1, mct_pkg::OFS_IRQ_EN, 32'h0000_0003);
        for (int k = 0; k < 6; k++) begin
            ax = int'(lfsr[1:0]);
            case (k % 3)
                0: run(4'h1 << ax, lfsr[3:2], 1'b0, k >= 3);
                1: run(4'h0, lfsr[3:2], 1'b0, k >= 3);
                default: run((4'h1 << ax) | (4'h1 << ((ax + 1) % 4)),
                             lfsr[3:2], 1'b0, k >= 3);
            endcase
            chk(irq, 1, "irq");
            apb(1'b1, mct_pkg::OFS_IRQ_CLR, 32'h0000_0003);
            apb(1'b0, mct_pkg::OFS_IRQ_STAT, 0);
            chk(rd, 0, "clear");
            chk(irq, 0, "irq off");
        end
        apb(1'b1, mct_pkg::OFS_TMO, 32'h0000_0002);
        // Thread 0 with handler, thread 1, then no handler
        for (int k = 0; k < 3; k++) begin
            ax = k;
            handlerDefined <= k != 2;
            run(4'h0, k == 1 ? 2'h1 : 2'h0, 1'b1, 1'b0);
            chk(settle >= 8 && settle <= 14, 1, "settle");
            apb(1'b0, mct_pkg::OFS_STOP, 0);
            chk(rd, 32'h0000_0063, "stop");
            apb(1'b0, mct_pkg::OFS_IRQ_STAT, 0);
            chk(rd[1], 1, "tmo");
            apb(1'b1, mct_pkg::OFS_IRQ_CLR, 32'h0000_0003);
        end
        close_out();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        close_out();
    end
endmodule : mct_motion_complete_bench
